/* File: core/mrs_pkg.sv */
// shared constants and types of the run/stop command logic
package mrs_pkg;
  localparam int          CLK_MHZ     = 125;
  localparam int          DEB_TIME_US = 10000;
  localparam int          DEB_CYCLES  = DEB_TIME_US * CLK_MHZ;

  localparam logic [7:0]  REG_CFG     = 8'h00;
  localparam logic [7:0]  REG_JOG     = 8'h04;
  localparam logic [7:0]  REG_REF     = 8'h08;
  localparam logic [7:0]  REG_STAT    = 8'h0C;

  localparam logic [3:0]  CFG_RESET   = 4'h1;
  localparam logic [15:0] JOG_RESET   = 16'h000F;
  localparam logic [3:0]  REF_RESET   = 4'h1;

  localparam logic [3:0]  CFG_EN_FR   = 4'h1;
  localparam logic [3:0]  CFG_3W_FR   = 4'h2;
  localparam logic [3:0]  CFG_EN_RR   = 4'h3;
  localparam logic [3:0]  CFG_3W_RR   = 4'h4;
  localparam logic [3:0]  CFG_RUNJOG  = 4'h5;
  localparam logic [3:0]  CFG_2W_FR   = 4'h6;
  localparam logic [3:0]  CFG_2W_RR   = 4'h7;
  localparam logic [3:0]  CFG_KEY     = 4'h8;
  localparam logic [3:0]  CFG_KEY_EN  = 4'h9;
  localparam logic [3:0]  CFG_KEY_JOG = 4'hA;

  localparam int          ST_B_RUN    = 0;
  localparam int          ST_B_JOG    = 1;
  localparam int          ST_B_REV    = 2;
  localparam int          ST_B_DECEL  = 3;
  localparam int          ST_B_COAST  = 4;
  localparam int          ST_B_LATCH  = 5;
  localparam int          ST_B_EN     = 6;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RUN   = 5'h02,
    ST_TURN  = 5'h04,
    ST_JOG   = 5'h08,
    ST_COAST = 5'h10
  } mrs_state_t;
endpackage

/* File: core/mrs_cfg_if.sv */
// settings and status between register slave and command core
interface mrs_cfg_if;
  logic [3:0]  cfg_sel;
  logic [15:0] jog_freq;
  logic [3:0]  ref_src;
  logic [7:0]  status;
  modport regs (output cfg_sel, output jog_freq, output ref_src, input status);
  modport core (input cfg_sel, input jog_freq, input ref_src, output status);
endinterface

/* File: core/mrs_debounce.sv */
// two-flop synchroniser and per-bit debounce filter
module mrs_debounce import mrs_pkg::*; #(
  parameter int W   = 6,
  parameter int CNT = DEB_CYCLES
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_raw,
  output logic      [W-1:0] o_clean
);
  localparam int CW = $clog2(CNT + 1);
  localparam logic [CW-1:0] LAST = CW'(CNT - 1);

  typedef struct packed {
    logic [W-1:0]          s1;
    logic [W-1:0]          s2;
    logic [W-1:0]          stable;
    logic [W-1:0][CW-1:0]  cnt;
  } mrs_deb_t;

  mrs_deb_t s_ff, nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.s1 = i_raw;
    nxt_s.s2 = s_ff.s1;
    for (int i = 0; i < W; i++) begin
      if (s_ff.s2[i] == s_ff.stable[i]) begin
        nxt_s.cnt[i] = '0;
      end else if (s_ff.cnt[i] == LAST) begin
        nxt_s.stable[i] = s_ff.s2[i];
        nxt_s.cnt[i] = '0;
      end else begin
        nxt_s.cnt[i] = s_ff.cnt[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_clean = s_ff.stable;
endmodule

/* File: core/mrs_wb_regs.sv */
// classic wishbone slave holding the drive settings
module mrs_wb_regs import mrs_pkg::*; (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  mrs_cfg_if.regs          cfg
);
  typedef struct packed {
    logic [3:0]  cfg;
    logic [15:0] jog;
    logic [3:0]  ref_src;
    logic [31:0] dat;
    logic        ack;
  } mrs_regs_t;

  mrs_regs_t s_ff, nxt_s;
  logic      req;

  always_comb begin
    nxt_s = s_ff;
    req = i_wb_cyc & i_wb_stb & ~s_ff.ack;
    nxt_s.ack = req;
    nxt_s.dat = '0;
    if (req && i_wb_we) begin
      // out-of-range selections are dropped so the core never sees one
      if (i_wb_adr == REG_CFG) begin
        if (i_wb_sel[0] && i_wb_dat[3:0] >= CFG_EN_FR && i_wb_dat[3:0] <= CFG_KEY_JOG) begin
          nxt_s.cfg = i_wb_dat[3:0];
        end
      end else if (i_wb_adr == REG_JOG) begin
        if (i_wb_sel[0]) nxt_s.jog[7:0] = i_wb_dat[7:0];
        if (i_wb_sel[1]) nxt_s.jog[15:8] = i_wb_dat[15:8];
      end else if (i_wb_adr == REG_REF) begin
        if (i_wb_sel[0]) nxt_s.ref_src = i_wb_dat[3:0];
      end
    end else if (req) begin
      if (i_wb_adr == REG_CFG) begin
        nxt_s.dat = {28'h0000000, s_ff.cfg};
      end else if (i_wb_adr == REG_JOG) begin
        nxt_s.dat = {16'h0000, s_ff.jog};
      end else if (i_wb_adr == REG_REF) begin
        nxt_s.dat = {28'h0000000, s_ff.ref_src};
      end else if (i_wb_adr == REG_STAT) begin
        nxt_s.dat = {24'h000000, cfg.status};
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_ff <= '{cfg: CFG_RESET, jog: JOG_RESET, ref_src: REF_RESET,
                dat: 32'h00000000, ack: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_wb_dat     = s_ff.dat;
  assign o_wb_ack     = s_ff.ack;
  assign cfg.cfg_sel  = s_ff.cfg;
  assign cfg.jog_freq = s_ff.jog;
  assign cfg.ref_src  = s_ff.ref_src;
endmodule

/* File: core/mrs_top.sv */
// run/stop command decoder for terminals and keypad
module mrs_top import mrs_pkg::*; #(
  parameter int DEB_CNT = DEB_CYCLES
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_din2,
  input  wire logic        i_din3,
  input  wire logic        i_din4,
  input  wire logic        i_key_up,
  input  wire logic        i_key_down,
  input  wire logic        i_key_stop,
  input  wire logic        i_ref_negative,
  input  wire logic        i_at_zero_hz,
  output logic             o_run_req,
  output logic             o_jog_req,
  output logic             o_reverse,
  output logic             o_decel_zero,
  output logic             o_coast,
  output logic      [15:0] o_jog_freq,
  output logic      [3:0]  o_ref_src_sel
);
  typedef struct packed {
    mrs_state_t st;
    logic       rev;
    logic       latch;
    logic       latch_rev;
    logic       combo_q;
    logic       stop_q;
    logic [3:0] cfg_q;
    logic       run;
    logic       jog;
    logic       decel;
    logic       coast;
  } mrs_core_t;

  localparam mrs_core_t CORE_RESET = '{
    st: ST_IDLE, rev: 1'b0, latch: 1'b0, latch_rev: 1'b0,
    combo_q: 1'b0, stop_q: 1'b0, cfg_q: CFG_RESET,
    run: 1'b0, jog: 1'b0, decel: 1'b0, coast: 1'b0
  };

  mrs_cfg_if  cfg ();
  mrs_core_t  s_ff, nxt_s;
  logic [5:0] clean;

  logic       en2;
  logic       in3;
  logic       in4;
  logic       k_up;
  logic       k_dn;
  logic       k_stop;
  logic       combo;
  logic       combo_p;
  logic       stop_p;
  logic       cmd_run;
  logic       cmd_rev;
  logic       cmd_jog;
  logic       clash;
  logic       drop_en;

  mrs_debounce #(
    .W   (6),
    .CNT (DEB_CNT)
  ) u_deb (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_raw     ({i_key_stop, i_key_down, i_key_up, i_din4, i_din3, i_din2}),
    .o_clean   (clean)
  );

  mrs_wb_regs u_regs (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_wb_cyc  (i_wb_cyc),
    .i_wb_stb  (i_wb_stb),
    .i_wb_we   (i_wb_we),
    .i_wb_adr  (i_wb_adr),
    .i_wb_sel  (i_wb_sel),
    .i_wb_dat  (i_wb_dat),
    .o_wb_dat  (o_wb_dat),
    .o_wb_ack  (o_wb_ack),
    .cfg       (cfg)
  );

  assign en2    = clean[0];
  assign in3    = clean[1];
  assign in4    = clean[2];
  assign k_up   = clean[3];
  assign k_dn   = clean[4];
  assign k_stop = clean[5];
  assign combo  = k_up & k_dn;

  // command decode per configuration
  always_comb begin
    nxt_s = s_ff;
    nxt_s.combo_q = combo;
    nxt_s.stop_q = k_stop;
    nxt_s.cfg_q = cfg.cfg_sel;
    combo_p = combo & ~s_ff.combo_q;
    stop_p = k_stop & ~s_ff.stop_q;
    cmd_run = 1'b0;
    cmd_rev = 1'b0;
    cmd_jog = 1'b0;
    clash = 1'b0;
    drop_en = 1'b0;
    case (cfg.cfg_sel)
      CFG_EN_FR: begin
        cmd_run = en2 & (in3 ^ in4);
        cmd_rev = in4;
        clash = en2 & in3 & in4;
      end
      CFG_3W_FR: begin
        if (!en2) begin
          nxt_s.latch = 1'b0;
        end else if (in3 && !in4) begin
          nxt_s.latch = 1'b1;
          nxt_s.latch_rev = 1'b0;
        end else if (in4 && !in3) begin
          nxt_s.latch = 1'b1;
          nxt_s.latch_rev = 1'b1;
        end
        cmd_run = s_ff.latch & en2;
        cmd_rev = s_ff.latch_rev;
      end
      CFG_EN_RR: begin
        cmd_run = en2 & in3;
        cmd_rev = in4;
      end
      CFG_3W_RR, CFG_RUNJOG: begin
        if (!en2) begin
          nxt_s.latch = 1'b0;
        end else if (in3) begin
          nxt_s.latch = 1'b1;
        end
        cmd_run = s_ff.latch & en2;
        if (cfg.cfg_sel == CFG_3W_RR) begin
          cmd_rev = in4;
        end else begin
          cmd_rev = i_ref_negative;
          cmd_jog = in4 & ~cmd_run;
        end
      end
      CFG_2W_FR: begin
        cmd_run = in3 ^ in4;
        cmd_rev = in4;
        clash = in3 & in4;
      end
      CFG_2W_RR: begin
        cmd_run = in3;
        cmd_rev = in4;
      end
      CFG_KEY: begin
        // stop wins when pressed in the same cycle as the combo
        if (stop_p) begin
          nxt_s.latch = 1'b0;
        end else if (combo_p) begin
          nxt_s.latch = 1'b1;
        end
        cmd_run = s_ff.latch;
      end
      CFG_KEY_EN: begin
        if (!en2) begin
          nxt_s.latch = 1'b0;
          drop_en = s_ff.latch;
        end else if (stop_p) begin
          nxt_s.latch = 1'b0;
        end else if (combo_p) begin
          nxt_s.latch = 1'b1;
        end
        cmd_run = s_ff.latch & en2;
      end
      CFG_KEY_JOG: begin
        cmd_jog = combo;
      end
      default: begin
        cmd_run = 1'b0;
      end
    endcase

    // a new configuration never inherits a latched run
    if (cfg.cfg_sel != s_ff.cfg_q) begin
      nxt_s.latch = 1'b0;
    end

    case (s_ff.st)
      ST_IDLE: begin
        if (cmd_jog) begin
          nxt_s.st = ST_JOG;
          nxt_s.rev = 1'b0;
        end else if (cmd_run && !clash) begin
          nxt_s.st = ST_RUN;
          nxt_s.rev = cmd_rev;
        end
      end
      ST_RUN: begin
        if (drop_en) begin
          nxt_s.st = ST_COAST;
        end else if (!cmd_run || clash) begin
          nxt_s.st = ST_IDLE;
        end else if (cmd_rev != s_ff.rev) begin
          nxt_s.st = ST_TURN;
        end
      end
      ST_TURN: begin
        if (drop_en) begin
          nxt_s.st = ST_COAST;
        end else if (!cmd_run || clash) begin
          nxt_s.st = ST_IDLE;
        end else if (cmd_rev == s_ff.rev) begin
          nxt_s.st = ST_RUN;
        end else if (i_at_zero_hz) begin
          nxt_s.st = ST_RUN;
          nxt_s.rev = cmd_rev;
        end
      end
      ST_JOG: begin
        if (!cmd_jog) begin
          nxt_s.st = ST_IDLE;
        end
      end
      ST_COAST: begin
        // the output stays off until the motor has spun down
        if (i_at_zero_hz) begin
          nxt_s.st = ST_IDLE;
        end
      end
      default: begin
        nxt_s.st = ST_IDLE;
      end
    endcase

    nxt_s.run = (nxt_s.st == ST_RUN) | (nxt_s.st == ST_TURN);
    nxt_s.jog = nxt_s.st == ST_JOG;
    nxt_s.decel = (nxt_s.st == ST_TURN) | clash;
    nxt_s.coast = nxt_s.st == ST_COAST;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_ff <= CORE_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_comb begin
    cfg.status = 8'h00;
    cfg.status[ST_B_RUN] = s_ff.run;
    cfg.status[ST_B_JOG] = s_ff.jog;
    cfg.status[ST_B_REV] = s_ff.rev;
    cfg.status[ST_B_DECEL] = s_ff.decel;
    cfg.status[ST_B_COAST] = s_ff.coast;
    cfg.status[ST_B_LATCH] = s_ff.latch;
    cfg.status[ST_B_EN] = en2;
  end

  assign o_run_req     = s_ff.run;
  assign o_jog_req     = s_ff.jog;
  assign o_reverse     = s_ff.rev;
  assign o_decel_zero  = s_ff.decel;
  assign o_coast       = s_ff.coast;
  assign o_jog_freq    = cfg.jog_freq;
  assign o_ref_src_sel = cfg.ref_src;
endmodule

/* File: testbench/mrs_ops.sv */
// operator panel model: terminal switches and keypad buttons
module mrs_ops (
  input  wire logic       i_ref_clk,
  input  wire logic [5:0] i_want,
  output logic      [5:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // open switches read low; levels move only just after an edge
  initial o_pins = 6'h00;
  always @(posedge i_ref_clk) begin
    o_pins <= i_want;
  end
endmodule

/* File: testbench/mrs_top_chk.sv */
// port assertions for the run/stop decoder
module mrs_top_chk (
  input wire logic        i_ref_clk,
  input wire logic        i_resetn,
  input wire logic        i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_at_zero_hz,
  input wire logic        o_run_req,
  input wire logic        o_jog_req,
  input wire logic        o_reverse,
  input wire logic        o_decel_zero,
  input wire logic        o_coast,
  input wire logic [15:0] o_jog_freq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  rst_vals_a: assert property (
    $rose(i_resetn) |-> o_jog_freq == 16'h000F && !o_run_req && !o_jog_req)
    else $error("outputs not at reset values");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_stb))
    else $error("ack without request");
  rd_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack");
  coast_off_a: assert property (o_coast |-> !o_run_req && !o_jog_req)
    else $error("coast while driving");
  turn_zero_a: assert property (
    $rose(o_reverse) && $past(o_run_req) |-> $past(o_decel_zero) && $past(i_at_zero_hz))
    else $error("direction flipped before zero");
  jog_fwd_a: assert property (o_jog_req |-> !o_reverse && !o_run_req)
    else $error("jog not forward or mixed with run");
  run_start_a: assert property ($rose(o_run_req) |-> !o_decel_zero && !o_coast)
    else $error("run started while stopping");
endmodule
bind mrs_top mrs_top_chk u_mrs_top_chk (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .i_at_zero_hz(i_at_zero_hz), .o_run_req(o_run_req),
  .o_jog_req(o_jog_req), .o_reverse(o_reverse), .o_decel_zero(o_decel_zero),
  .o_coast(o_coast), .o_jog_freq(o_jog_freq));

/* File: testbench/tb_mrs_top.sv */
// self-checking bench for the run/stop command decoder
module tb_mrs_top import mrs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        at0 = 1'b0;
  logic        neg = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dout;
  logic        ack;
  logic [5:0]  want = 6'h00;
  logic [5:0]  pins;
  logic [4:0]  cmd;
  logic [15:0] jogf;
  logic [3:0]  refs;
  logic [15:0] rj;
  logic [3:0]  rr;
  int          errors = 0;
  int          checks_done = 0;
  int          cur = 1;

  mrs_ops u_mrs_ops (.i_ref_clk(clk), .i_want(want), .o_pins(pins));
  // pins {din2,din3,din4,up,down,stop}; cmd {run,jog,reverse,decel_zero,coast}
  mrs_top #(.DEB_CNT(4)) u_mrs_top (
    .i_ref_clk(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(dout), .o_wb_ack(ack),
    .i_din2(pins[5]), .i_din3(pins[4]), .i_din4(pins[3]), .i_key_up(pins[2]),
    .i_key_down(pins[1]), .i_key_stop(pins[0]), .i_ref_negative(neg),
    .i_at_zero_hz(at0), .o_run_req(cmd[4]), .o_jog_req(cmd[3]), .o_reverse(cmd[2]),
    .o_decel_zero(cmd[1]), .o_coast(cmd[0]), .o_jog_freq(jogf), .o_ref_src_sel(refs));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // reads ack before the edge's own updates land, so no race with the slave
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
  endtask

  // direction is only compared while the motor is driven
  task automatic step(logic [5:0] p, logic [4:0] e, string n);
    want <= p;
    repeat (16) @(posedge clk);
    chk(n, 32'({cmd[4:3], cmd[2] & (cmd[4] | cmd[3]), cmd[1:0]}), 32'(e));
  endtask

  task automatic cfg(logic [3:0] c);
    step(6'h00, 5'h00, "stop");
    $display("test %0d done", cur);
    cur = int'(c);
    wb(1'b1, REG_CFG, 32'(c));
  endtask

  initial begin
    void'($urandom(48723));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, REG_CFG, 32'h0);
    chk("cfg reset", rdat, 32'h1);
    wb(1'b0, REG_JOG, 32'h0);
    chk("jog reset", rdat, 32'h0000000F);
    rj = 16'($urandom);
    rr = 4'($urandom);
    wb(1'b1, REG_REF, 32'(rr));
    wb(1'b1, REG_JOG, 32'(rj));
    wb(1'b1, REG_CFG, 32'h0);
    wb(1'b0, REG_CFG, 32'h0);
    chk("cfg refused", rdat, 32'h1);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", rdat, 32'h0);
    chk("ref source", 32'(refs), 32'(rr));
    chk("jog freq", 32'(jogf), 32'(rj));
    step(6'h10, 5'h00, "c1 no enable");
    step(6'h30, 5'h10, "c1 fwd");
    wb(1'b0, REG_STAT, 32'h0);
    chk("c1 status", rdat, 32'((1 << ST_B_RUN) | (1 << ST_B_EN)));
    step(6'h31, 5'h10, "c1 key stop");
    step(6'h38, 5'h02, "c1 clash");
    step(6'h28, 5'h14, "c1 rev");
    cfg(4'h2);
    step(6'h30, 5'h10, "c2 pulse");
    step(6'h20, 5'h10, "c2 latched");
    step(6'h28, 5'h12, "c2 turn");
    at0 <= 1'b1;
    step(6'h28, 5'h14, "c2 reversed");
    step(6'h00, 5'h00, "c2 permit off");
    at0 <= 1'b0;
    cfg(4'h3);
    step(6'h10, 5'h00, "c3 no enable");
    step(6'h30, 5'h10, "c3 run");
    step(6'h38, 5'h12, "c3 turn");
    at0 <= 1'b1;
    step(6'h38, 5'h14, "c3 reversed");
    at0 <= 1'b0;
    cfg(4'h4);
    step(6'h30, 5'h10, "c4 run");
    step(6'h20, 5'h10, "c4 latched");
    step(6'h28, 5'h12, "c4 turn");
    at0 <= 1'b1;
    step(6'h28, 5'h14, "c4 reversed");
    step(6'h08, 5'h00, "c4 permit off");
    at0 <= 1'b0;
    cfg(4'h5);
    step(6'h08, 5'h08, "c5 jog");
    neg <= 1'b1;
    step(6'h30, 5'h14, "c5 negative ref");
    step(6'h20, 5'h14, "c5 latched");
    cfg(4'h6);
    neg <= 1'b0;
    step(6'h08, 5'h14, "c6 rev");
    step(6'h18, 5'h02, "c6 clash");
    step(6'h10, 5'h10, "c6 fwd");
    cfg(4'h7);
    step(6'h10, 5'h10, "c7 run");
    step(6'h18, 5'h12, "c7 turn");
    at0 <= 1'b1;
    step(6'h18, 5'h14, "c7 reversed");
    at0 <= 1'b0;
    cfg(4'h8);
    step(6'h06, 5'h10, "c8 combo");
    step(6'h00, 5'h10, "c8 held");
    wb(1'b0, REG_STAT, 32'h0);
    chk("c8 status", rdat, 32'((1 << ST_B_RUN) | (1 << ST_B_LATCH)));
    step(6'h01, 5'h00, "c8 stop");
    cfg(4'h9);
    step(6'h06, 5'h00, "c9 no enable");
    step(6'h20, 5'h00, "c9 enabled");
    step(6'h26, 5'h10, "c9 run");
    step(6'h21, 5'h00, "c9 stop");
    step(6'h26, 5'h10, "c9 rerun");
    step(6'h00, 5'h01, "c9 coast");
    at0 <= 1'b1;
    cfg(4'hA);
    at0 <= 1'b0;
    step(6'h06, 5'h08, "c10 jog");
    step(6'h04, 5'h00, "c10 release");
    $display("test %0d done", cur);
    // a reset after the keypad jog is released must bring back the default configuration and settings
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, REG_CFG, 32'h0);
    chk("cfg after reset", rdat, 32'(CFG_RESET));
    chk("ref after reset", 32'(refs), 32'(REF_RESET));
    chk("jog after reset", 32'(jogf), 32'(JOG_RESET));
    step(6'h30, 5'h10, "reset c1 fwd");
    $display("test reset done");
    end_of_test();
  end
endmodule
